/* cfg_host.sv */
// Purpose: root complex side model issuing configuration requests to the register bank
// Assumes: caller enters each access just after a rising clock edge
// Notes: the answer is read 1 ns after the taking edge, while it stands; one request per call
`timescale 1ns/1ps
module cfg_host (
   input wire logic clock,
   output devcap_pkg::cfg_req_t cfg_req,
   input wire devcap_pkg::cfg_rsp_t cfg_rsp
);
   initial cfg_req = '0;

   // hold keeps valid up so a follow-on request goes out back to back without a glitch
   task automatic access(input logic write, input logic [11:0] addr, input logic [3:0] byte_en,
      input logic [31:0] wdata, input bit hold, output logic valid, output logic [31:0] rdata);
      cfg_req.valid = 1'b1;
      cfg_req.write = write;
      cfg_req.addr = addr;
      cfg_req.byte_en = byte_en;
      cfg_req.wdata = wdata;
      @(posedge clock);
      #1;
      valid = cfg_rsp.valid;
      rdata = cfg_rsp.rdata;
      if (!hold) begin
         // a released bus must not keep showing the last value
         cfg_req.valid = 1'b0;
         cfg_req.addr = ~addr;
         cfg_req.wdata = ~wdata;
         // one idle edge keeps the next call from raising valid in this same step
         @(posedge clock);
         #1;
      end
   endtask
endmodule

/* devcap_pkg.sv */
// Purpose: shared constants and carriers for the endpoint capability/control registers
// Assumes: configuration requests address aligned dwords by byte address
// Notes: power scale codes are held as milliwatts per unit of captured value
package devcap_pkg;

   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CAP_OFFSET = 12'h074;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h078;

   localparam logic [31:0] CAP_RESET = 32'h0000_8FC3;
   localparam logic [15:0] CTRL_RESET = 16'h2810;
   // bit 15 is a self-clearing trigger and bit 9 is read-only zero
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h7DFF;

   localparam int CAP_SCALE_HI = 27;
   localparam int CAP_SCALE_LO = 26;
   localparam int CAP_VALUE_HI = 25;
   localparam int CAP_VALUE_LO = 18;
   localparam int CAP_ROLE_ERR = 15;
   localparam int CAP_L1_HI = 11;
   localparam int CAP_L1_LO = 9;
   localparam int CAP_L0S_HI = 8;
   localparam int CAP_L0S_LO = 6;
   localparam int CTRL_FUNC_RESET = 15;

   localparam int MSG_SCALE_HI = 9;
   localparam int MSG_SCALE_LO = 8;
   localparam int MSG_VALUE_HI = 7;
   localparam int MSG_VALUE_LO = 0;

   localparam logic [2:0] MAX_PAYLOAD_1K = 3'h3;
   localparam logic [1:0] PHANTOM_NONE = 2'h0;
   localparam logic EXT_TAG_NONE = 1'h0;
   localparam logic FUNC_RESET_NONE = 1'h0;
   localparam logic ROLE_ERR_YES = 1'h1;

   // slot power in milliwatts per unit of captured value, by scale code
   localparam logic [9:0] MW_SCALE_1 = 10'h3E8;
   localparam logic [9:0] MW_SCALE_0P1 = 10'h064;
   localparam logic [9:0] MW_SCALE_0P01 = 10'h00A;
   localparam logic [9:0] MW_SCALE_0P001 = 10'h001;
   localparam int POWER_MW_W = 18;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } cfg_rsp_t;

   typedef struct packed {
      logic valid;
      logic [9:0] payload;
   } slot_msg_t;

endpackage

/* devcap_regs.sv */
// Purpose: capability and control dwords of an express endpoint configuration space
// Assumes: one configuration request per cycle at most, answered the next cycle
// Notes: other dwords answer zero; the upper half of the control dword is not held here
`timescale 1ns/1ps

module devcap_regs (
   input wire logic clock,
   input wire logic reset,
   input wire devcap_pkg::cfg_req_t cfg_req,
   input wire devcap_pkg::slot_msg_t slot_msg,
   input wire logic [2:0] setting_a,
   input wire logic [2:0] setting_b,
   input wire logic [2:0] phy_setting_a,
   input wire logic [2:0] phy_setting_b,
   output devcap_pkg::cfg_rsp_t cfg_rsp,
   output logic [15:0] device_control,
   output logic func_reset_req,
   output logic [devcap_pkg::POWER_MW_W-1:0] slot_power_mw
);

   logic [1:0] captured_power_scale;
   logic [7:0] captured_power_value;
   logic [2:0] l1_exit_accept_latency;
   logic [2:0] l0s_exit_accept_latency;
   logic [31:0] cap_word;
   logic [1:0] next_scale;
   logic [7:0] next_value;
   logic [15:0] next_control;
   logic next_func_reset;
   devcap_pkg::cfg_rsp_t next_rsp;
   logic [devcap_pkg::POWER_MW_W-1:0] next_power_mw;
   logic [9:0] mw_per_unit;
   logic hit_cap;
   logic hit_ctrl;
   logic rsp_was_cap;
   logic next_rsp_was_cap;

   exit_latency_floor #(
      .WIDTH(3)
   ) u_l1_floor (
      .clock(clock),
      .reset(reset),
      .setting(setting_a),
      .phy_latency(phy_setting_a),
      .latency(l1_exit_accept_latency)
   );

   exit_latency_floor #(
      .WIDTH(3)
   ) u_l0s_floor (
      .clock(clock),
      .reset(reset),
      .setting(setting_b),
      .phy_latency(phy_setting_b),
      .latency(l0s_exit_accept_latency)
   );

   // capability dword built from constants and live fields
   always_comb begin
      cap_word = '0;
      cap_word[28] = devcap_pkg::FUNC_RESET_NONE;
      cap_word[devcap_pkg::CAP_SCALE_HI:devcap_pkg::CAP_SCALE_LO] = captured_power_scale;
      cap_word[devcap_pkg::CAP_VALUE_HI:devcap_pkg::CAP_VALUE_LO] = captured_power_value;
      cap_word[devcap_pkg::CAP_ROLE_ERR] = devcap_pkg::ROLE_ERR_YES;
      cap_word[devcap_pkg::CAP_L1_HI:devcap_pkg::CAP_L1_LO] = l1_exit_accept_latency;
      cap_word[devcap_pkg::CAP_L0S_HI:devcap_pkg::CAP_L0S_LO] = l0s_exit_accept_latency;
      cap_word[5] = devcap_pkg::EXT_TAG_NONE;
      cap_word[4:3] = devcap_pkg::PHANTOM_NONE;
      cap_word[2:0] = devcap_pkg::MAX_PAYLOAD_1K;
   end

   always_comb begin
      hit_cap = (cfg_req.addr == devcap_pkg::CAP_OFFSET);
      hit_ctrl = (cfg_req.addr == devcap_pkg::CTRL_OFFSET);
   end

   // captured slot power fields; configuration writes never reach them
   always_comb begin
      next_scale = captured_power_scale;
      next_value = captured_power_value;
      if (slot_msg.valid) begin
         next_scale = slot_msg.payload[devcap_pkg::MSG_SCALE_HI:devcap_pkg::MSG_SCALE_LO];
         next_value = slot_msg.payload[devcap_pkg::MSG_VALUE_HI:devcap_pkg::MSG_VALUE_LO];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         captured_power_scale <= '0;
         captured_power_value <= '0;
      end else begin
         captured_power_scale <= next_scale;
         captured_power_value <= next_value;
      end
   end

   // scale decode into a milliwatt limit; one cycle behind the captured fields
   always_comb begin
      case (captured_power_scale)
         2'h0: mw_per_unit = devcap_pkg::MW_SCALE_1;
         2'h1: mw_per_unit = devcap_pkg::MW_SCALE_0P1;
         2'h2: mw_per_unit = devcap_pkg::MW_SCALE_0P01;
         default: mw_per_unit = devcap_pkg::MW_SCALE_0P001;
      endcase
      // both factors widened so the product keeps all of its bits
      next_power_mw = devcap_pkg::POWER_MW_W'({10'h000, captured_power_value}
         * {8'h00, mw_per_unit});
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         slot_power_mw <= '0;
      end else begin
         slot_power_mw <= next_power_mw;
      end
   end

   // control register; byte enables pick the lanes, bit 15 only pulses
   always_comb begin
      next_control = device_control;
      next_func_reset = 1'b0;
      if (cfg_req.valid && cfg_req.write && hit_ctrl) begin
         if (cfg_req.byte_en[0]) begin
            next_control[7:0] = cfg_req.wdata[7:0] & devcap_pkg::CTRL_WRITE_MASK[7:0];
         end
         if (cfg_req.byte_en[1]) begin
            next_control[15:8] = cfg_req.wdata[15:8] & devcap_pkg::CTRL_WRITE_MASK[15:8];
            next_func_reset = cfg_req.wdata[devcap_pkg::CTRL_FUNC_RESET];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         device_control <= devcap_pkg::CTRL_RESET;
         func_reset_req <= 1'b0;
      end else begin
         device_control <= next_control;
         func_reset_req <= next_func_reset;
      end
   end

   // every request gets one answer the next cycle; unmapped dwords read zero
   always_comb begin
      next_rsp = '0;
      next_rsp_was_cap = 1'b0;
      if (cfg_req.valid) begin
         next_rsp.valid = 1'b1;
         if (!cfg_req.write && hit_cap) begin
            next_rsp.rdata = cap_word;
            next_rsp_was_cap = 1'b1;
         end else if (!cfg_req.write && hit_ctrl) begin
            next_rsp.rdata = {16'h0000, device_control};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cfg_rsp <= '0;
         rsp_was_cap <= 1'b0;
      end else begin
         cfg_rsp <= next_rsp;
         rsp_was_cap <= next_rsp_was_cap;
      end
   end

   sequence s_message;
      slot_msg.valid;
   endsequence

   sequence s_no_message;
      !slot_msg.valid;
   endsequence

   property p_reserved_zero;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> (cfg_rsp.rdata[31:29] == 3'h0 && cfg_rsp.rdata[17:16] == 2'h0
         && cfg_rsp.rdata[14:12] == 3'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_no_func_reset_cap;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> !cfg_rsp.rdata[28];
   endproperty
   a_no_func_reset_cap: assert property (p_no_func_reset_cap) else $error("bit 28 set");

   property p_scale_capture;
      @(posedge clock) disable iff (reset)
      s_message |=> captured_power_scale == $past(slot_msg.payload[9:8]);
   endproperty
   a_scale_capture: assert property (p_scale_capture) else $error("scale not captured");

   localparam int POWER_MW_W = devcap_pkg::POWER_MW_W;

   property p_scale_decode;
      @(posedge clock) disable iff (reset)
      (s_message ##1 s_no_message ##1 s_no_message) |->
         slot_power_mw == POWER_MW_W'($past(slot_msg.payload[7:0], 2) *
         ($past(slot_msg.payload[9:8], 2) == 2'h0 ? 1000 :
          $past(slot_msg.payload[9:8], 2) == 2'h1 ? 100 :
          $past(slot_msg.payload[9:8], 2) == 2'h2 ? 10 : 1));
   endproperty
   a_scale_decode: assert property (p_scale_decode) else $error("power limit decode wrong");

   property p_value_capture;
      @(posedge clock) disable iff (reset)
      s_message |=> captured_power_value == $past(slot_msg.payload[7:0]);
   endproperty
   a_value_capture: assert property (p_value_capture) else $error("value not captured");

   property p_role_err;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> cfg_rsp.rdata[15];
   endproperty
   a_role_err: assert property (p_role_err) else $error("role error bit clear");

   property p_l1_field;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> cfg_rsp.rdata[11:9] == $past(l1_exit_accept_latency);
   endproperty
   a_l1_field: assert property (p_l1_field) else $error("Setting_a field wrong");

   property p_l0s_field;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> cfg_rsp.rdata[8:6] == $past(l0s_exit_accept_latency);
   endproperty
   a_l0s_field: assert property (p_l0s_field) else $error("Setting_b field wrong");

   property p_low_bits;
      @(posedge clock) disable iff (reset)
      rsp_was_cap |-> cfg_rsp.rdata[5:0] == 6'h03;
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("bits 5:0 not 03h");

   property p_ctrl_reset;
      @(posedge clock)
      $past(reset) && !reset |-> device_control == 16'h2810 && !func_reset_req;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

   property p_ctrl_readback;
      @(posedge clock) disable iff (reset)
      (cfg_req.valid && cfg_req.write && cfg_req.addr == 12'h078 && cfg_req.byte_en[1:0] == 2'h3)
         ##1 (cfg_req.valid && !cfg_req.write && cfg_req.addr == 12'h078)
         |=> cfg_rsp.valid && cfg_rsp.rdata[15:0] == ($past(cfg_req.wdata[15:0], 2) & 16'h7DFF);
   endproperty
   a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

   property p_cap_after_reset;
      @(posedge clock)
      $past(reset) && !reset && cfg_req.valid && !cfg_req.write && hit_cap
         |=> cfg_rsp.rdata == devcap_pkg::CAP_RESET;
   endproperty
   a_cap_after_reset: assert property (p_cap_after_reset) else $error("cap reset value wrong");

   property p_power_stable;
      @(posedge clock) disable iff (reset)
      s_no_message |=> $stable(captured_power_scale) && $stable(captured_power_value);
   endproperty
   a_power_stable: assert property (p_power_stable) else $error("power fields moved");

   sequence s_ctrl_write;
      cfg_req.valid && cfg_req.write && hit_ctrl;
   endsequence

   // the trigger is a one-cycle request and must never be seen as a stored bit
   property p_ctrl_masked;
      @(posedge clock) disable iff (reset)
      s_ctrl_write |=> !device_control[devcap_pkg::CTRL_FUNC_RESET] && !device_control[9];
   endproperty
   a_ctrl_masked: assert property (p_ctrl_masked) else $error("control bit 15 or 9 stored");

   property p_func_reset_pulse;
      @(posedge clock) disable iff (reset)
      s_ctrl_write ##0 (cfg_req.byte_en[1] && cfg_req.wdata[15]) |=> func_reset_req;
   endproperty
   a_func_reset_pulse: assert property (p_func_reset_pulse) else $error("no reset pulse");

   property p_func_reset_cause;
      @(posedge clock) disable iff (reset)
      func_reset_req |-> $past(cfg_req.valid && cfg_req.write && hit_ctrl && cfg_req.byte_en[1]
         && cfg_req.wdata[15]);
   endproperty
   a_func_reset_cause: assert property (p_func_reset_cause) else $error("stray reset pulse");

   property p_answer_next;
      @(posedge clock) disable iff (reset)
      cfg_req.valid |=> cfg_rsp.valid;
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("request left unanswered");

endmodule

/* exit_latency_floor.sv */
// Purpose: registered acceptable exit latency, never below the phy's own latency
// Assumes: setting and phy latency are synchronous to clock
// Notes: one cycle from input change to output
`timescale 1ns/1ps
module exit_latency_floor #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [WIDTH-1:0] setting,
   input wire logic [WIDTH-1:0] phy_latency,
   output logic [WIDTH-1:0] latency
);

   logic [WIDTH-1:0] next_latency;

   // a setting below the phy latency would promise an exit the phy cannot make
   always_comb begin
      next_latency = (setting < phy_latency) ? phy_latency : setting;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         // all ones is the documented reset field and never sits below any phy latency
         latency <= '1;
      end else begin
         latency <= next_latency;
      end
   end

   property p_floor;
      @(posedge clock) disable iff (reset)
      !$past(reset) |-> (latency >= $past(phy_latency) && latency >= $past(setting));
   endproperty
   a_floor: assert property (p_floor) else $error("exit latency below floor or setting");

   property p_follow;
      @(posedge clock) disable iff (reset)
      (setting >= phy_latency) |=> (latency == $past(setting));
   endproperty
   a_follow: assert property (p_follow) else $error("exit latency ignores setting");

endmodule

/* tb.sv */
// Purpose: self-checking bench for the capability and control dwords
// Assumes: inputs change 1 ns after the rising edge, answers are read 1 ns after it
// Notes: expectations come from a small integer model of the two dwords
`timescale 1ns/1ps
module tb;
   logic clock;
   logic reset;
   devcap_pkg::cfg_req_t cfg_req;
   devcap_pkg::cfg_rsp_t cfg_rsp;
   devcap_pkg::slot_msg_t slot_msg;
   logic [2:0] setting_a, setting_b, phy_setting_a, phy_setting_b;
   logic [15:0] device_control;
   logic func_reset_req;
   logic [devcap_pkg::POWER_MW_W-1:0] slot_power_mw;
   int mismatches, total_checks, cycles;
   int m_scale, m_value;
   int mw[4] = '{1000, 100, 10, 1};
   logic [15:0] m_ctrl, lm;
   logic rv;
   logic [31:0] rd, d;
   logic [3:0] be;

   cfg_host host (.clock(clock), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   devcap_regs dut (.clock(clock), .reset(reset), .cfg_req(cfg_req), .slot_msg(slot_msg),
      .setting_a(setting_a), .setting_b(setting_b), .phy_setting_a(phy_setting_a),
      .phy_setting_b(phy_setting_b), .cfg_rsp(cfg_rsp), .device_control(device_control),
      .func_reset_req(func_reset_req), .slot_power_mw(slot_power_mw));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   function automatic int maxi(int x, int y);
      return (x > y) ? x : y;
   endfunction

   function automatic logic [31:0] cap_exp();
      return (m_scale << 26) | (m_value << 18) | 32'h0000_8000
         | (maxi(setting_a, phy_setting_a) << 9) | (maxi(setting_b, phy_setting_b) << 6)
         | 32'h0000_0003;
   endfunction

   task automatic summarize();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      host.access(1'b0, a, 4'h0, 32'h0, 1'b0, rv, rd);
      check(rv, 32'h1);
      check(rd, exp);
   endtask

   task automatic msg(input logic [9:0] p);
      slot_msg.valid = 1'b1;
      slot_msg.payload = p;
      @(posedge clock);
      #1;
      slot_msg.valid = 1'b0;
      slot_msg.payload = ~p;
      m_scale = p[9:8];
      m_value = p[7:0];
      @(posedge clock);
      #1;
      check(slot_power_mw, m_value * mw[m_scale]);
   endtask

   task automatic do_reset(input int n);
      reset = 1'b1;
      repeat (n) @(posedge clock);
      #1;
      reset = 1'b0;
      m_ctrl = 16'h2810;
      m_scale = 0;
      m_value = 0;
      // the first request goes out at the first edge after release
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      reset = 1'b1;
      slot_msg = '0;
      setting_a = 3'h7;
      setting_b = 3'h7;
      phy_setting_a = 3'h0;
      phy_setting_b = 3'h0;
      mismatches = 0;
      total_checks = 0;
      cycles = 0;
      d = $urandom(32'hA0BE);
      #1;
      do_reset(4);
      rd_chk(12'h074, 32'h0000_8FC3);
      rd_chk(12'h078, 32'h0000_2810);
      check(device_control, 16'h2810);
      rd_chk(12'h07C, 32'h0);
      for (int i = 0; i < 24; i++) begin
         {setting_a, setting_b, phy_setting_a, phy_setting_b} = 12'($urandom);
         // first four passes walk every scale code
         msg((i < 4) ? {i[1:0], 8'($urandom)} : 10'($urandom));
         host.access(1'b1, 12'h074, 4'hF, $urandom, 1'b1, rv, rd);
         rd_chk(12'h074, cap_exp());
         be = 4'($urandom);
         d = $urandom;
         host.access(1'b1, 12'h078, be, d, 1'b1, rv, rd);
         check(rv, 32'h1);
         check(rd, 32'h0);
         check(func_reset_req, be[1] & d[15]);
         lm = {{8{be[1]}}, {8{be[0]}}};
         m_ctrl = ((m_ctrl & ~lm) | (d[15:0] & lm)) & 16'h7DFF;
         rd_chk(12'h078, {16'h0, m_ctrl});
         check(device_control, m_ctrl);
      end
      do_reset(2);
      rd_chk(12'h074, 32'h0000_8FC3);
      rd_chk(12'h078, 32'h0000_2810);
      check(slot_power_mw, 32'h0);
      rd_chk(12'h074, cap_exp());
      summarize();
   end
endmodule
